// [pbf_port.sv]
// device side of the parallel byte fifo host port
`timescale 1ns/100ps
module pbf_port
  import pbf_pkg::*;
#(
  parameter int unsigned DATA_W = pbf_pkg::PBF_DATA_W,
  parameter int unsigned DEPTH  = pbf_pkg::PBF_DEPTH
) (
  input  wire logic                clk_sys_in,
  input  wire logic                reset_in,
  input  wire logic                sync_req_in,
  input  wire logic                pkg32_in,
  input  wire pbf_pkg::pbf_host_in_t host_in,
  output logic       [DATA_W-1:0]  host_data_out,
  output logic                     host_data_oe_n_out,
  output logic                     rxf_n_out,
  output logic                     txe_n_out,
  output logic                     clkout_out,
  input  wire logic                rx_push_in,
  input  wire logic  [DATA_W-1:0]  rx_push_data_in,
  output logic                     rx_space_out,
  input  wire logic                tx_pop_in,
  output logic       [DATA_W-1:0]  tx_data_out,
  output logic                     tx_valid_out,
  output logic                     tx_avail_out
);
  import pbf_pkg::*;

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PBF_HOLD_W-1:0] HOLD_LOAD = PBF_HOLD_W'(PBF_FLAG_HOLD_CYC - 1);
  localparam logic [PBF_HOLD_W-1:0] HOLD_SAT = '1;

  if (DATA_W != PBF_DATA_W || DEPTH < 2 || (1 << AW) != DEPTH || PBF_FLAG_HOLD_CYC > 255) begin : g_bad
    $error("pbf_port: width must be 8 and depth a power of two");
  end

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return p + 1'b1;
  endfunction

  function automatic logic [CW-1:0] cnt_next(input logic [CW-1:0] c, input logic push, input logic pop);
    unique case ({push, pop})
      2'b10:   return c + 1'b1;
      2'b01:   return c - 1'b1;
      default: return c;
    endcase
  endfunction

  logic            sync_reg;
  logic            rd_n_prev_reg;
  logic            wr_n_prev_reg;
  logic [AW-1:0]   rx_wptr_reg;
  logic [AW-1:0]   rx_rptr_reg;
  logic [CW-1:0]   rx_count_reg;
  logic [AW-1:0]   tx_wptr_reg;
  logic [AW-1:0]   tx_rptr_reg;
  logic [CW-1:0]   tx_count_reg;
  pbf_flag_state_t rx_st_reg;
  pbf_flag_state_t tx_st_reg;
  logic [PBF_HOLD_W-1:0] rx_hold_reg;
  logic [PBF_HOLD_W-1:0] tx_hold_reg;

  logic          async_rd_fall;
  logic          async_rd_rise;
  logic          async_wr_fall;
  logic          async_wr_rise;
  logic          sync_tick;
  logic          rd_req;
  logic          wr_req;
  logic          rx_pop;
  logic          rx_push;
  logic          tx_push;
  logic          tx_pop;
  logic [CW-1:0] rx_count_next;
  logic [CW-1:0] tx_count_next;

  // strobe edges, asynchronous mode only
  assign async_rd_fall = ~sync_reg & rd_n_prev_reg & ~host_in.rd_n;
  assign async_rd_rise = ~sync_reg & ~rd_n_prev_reg & host_in.rd_n;
  assign async_wr_fall = ~sync_reg & wr_n_prev_reg & ~host_in.wr_n;
  assign async_wr_rise = ~sync_reg & ~wr_n_prev_reg & host_in.wr_n;
  // synchronous transfers happen at each rising clkout
  assign sync_tick     = sync_reg & ~clkout_out;
  assign rd_req        = async_rd_fall | (sync_tick & ~host_in.rd_n);
  assign wr_req        = async_wr_fall | (sync_tick & ~host_in.wr_n);
  assign rx_pop        = rd_req & (rx_count_reg != '0);
  assign tx_push       = wr_req & (tx_count_reg != FULL_CNT);
  assign rx_push       = rx_push_in & (rx_count_reg != FULL_CNT);
  assign tx_pop        = tx_pop_in & (tx_count_reg != '0);
  assign rx_count_next = cnt_next(rx_count_reg, rx_push, rx_pop);
  assign tx_count_next = cnt_next(tx_count_reg, tx_push, tx_pop);

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sync_reg   <= 1'b0;
      clkout_out <= 1'b0;
    end else begin
      sync_reg   <= sync_req_in & ~pkg32_in;
      clkout_out <= sync_reg & ~clkout_out;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rd_n_prev_reg      <= 1'b1;
      wr_n_prev_reg      <= 1'b1;
      host_data_oe_n_out <= PBF_OE_N_RST;
    end else begin
      rd_n_prev_reg      <= host_in.rd_n;
      wr_n_prev_reg      <= host_in.wr_n;
      host_data_oe_n_out <= sync_reg ? host_in.oe_n : host_in.rd_n;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rx_wptr_reg  <= '0;
      rx_rptr_reg  <= '0;
      rx_count_reg <= '0;
      rx_space_out <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_wptr_reg <= ptr_inc(rx_wptr_reg);
      end
      if (rx_pop) begin
        rx_rptr_reg <= ptr_inc(rx_rptr_reg);
      end
      rx_count_reg <= rx_count_next;
      rx_space_out <= rx_count_next != FULL_CNT;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tx_wptr_reg  <= '0;
      tx_rptr_reg  <= '0;
      tx_count_reg <= '0;
      tx_valid_out <= 1'b0;
      tx_avail_out <= 1'b0;
    end else begin
      if (tx_push) begin
        tx_wptr_reg <= ptr_inc(tx_wptr_reg);
      end
      if (tx_pop) begin
        tx_rptr_reg <= ptr_inc(tx_rptr_reg);
      end
      tx_count_reg <= tx_count_next;
      tx_valid_out <= tx_pop;
      tx_avail_out <= tx_count_next != '0;
    end
  end

  // receive flag: unchanged during strobe, high for the hold after it
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rx_st_reg   <= PBF_FL_READY;
      rx_hold_reg <= '0;
      rxf_n_out   <= PBF_FLAG_RST;
    end else if (sync_reg) begin
      rx_st_reg <= PBF_FL_READY;
      rxf_n_out <= rx_count_next == '0;
    end else begin
      unique case (rx_st_reg)
        PBF_FL_READY: begin
          if (async_rd_fall) begin
            rx_st_reg <= PBF_FL_STROBE;
          end else begin
            rxf_n_out <= rx_count_next == '0;
          end
        end
        PBF_FL_STROBE: begin
          if (async_rd_rise) begin
            rx_st_reg   <= PBF_FL_HOLD;
            rx_hold_reg <= HOLD_LOAD;
            rxf_n_out   <= 1'b1;
          end
        end
        PBF_FL_HOLD: begin
          rxf_n_out <= 1'b1;
          if (rx_hold_reg == '0) begin
            rx_st_reg <= PBF_FL_READY;
          end else begin
            rx_hold_reg <= rx_hold_reg - 1'b1;
          end
        end
        default: rx_st_reg <= PBF_FL_READY;
      endcase
    end
  end

  // transmit flag: forced high by every asynchronous write strobe
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tx_st_reg   <= PBF_FL_READY;
      tx_hold_reg <= '0;
      txe_n_out   <= PBF_FLAG_RST;
    end else if (sync_reg) begin
      tx_st_reg <= PBF_FL_READY;
      txe_n_out <= tx_count_next == FULL_CNT;
    end else begin
      unique case (tx_st_reg)
        PBF_FL_READY: begin
          if (async_wr_fall) begin
            tx_st_reg <= PBF_FL_STROBE;
            txe_n_out <= 1'b1;
          end else begin
            txe_n_out <= tx_count_next == FULL_CNT;
          end
        end
        PBF_FL_STROBE: begin
          txe_n_out <= 1'b1;
          if (async_wr_rise) begin
            tx_st_reg   <= PBF_FL_HOLD;
            tx_hold_reg <= HOLD_LOAD;
          end
        end
        PBF_FL_HOLD: begin
          txe_n_out <= 1'b1;
          if (tx_hold_reg == '0) begin
            tx_st_reg <= PBF_FL_READY;
          end else begin
            tx_hold_reg <= tx_hold_reg - 1'b1;
          end
        end
        default: tx_st_reg <= PBF_FL_READY;
      endcase
    end
  end

  pbf_mem #(.WIDTH(DATA_W), .DEPTH(DEPTH), .AW(AW)) u_rx_mem (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (reset_in),
    .wr_en_in    (rx_push),
    .wr_addr_in  (rx_wptr_reg),
    .wr_data_in  (rx_push_data_in),
    .rd_en_in    (rx_pop),
    .rd_addr_in  (rx_rptr_reg),
    .rd_data_out (host_data_out)
  );

  pbf_mem #(.WIDTH(DATA_W), .DEPTH(DEPTH), .AW(AW)) u_tx_mem (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (reset_in),
    .wr_en_in    (tx_push),
    .wr_addr_in  (tx_wptr_reg),
    .wr_data_in  (host_in.data),
    .rd_en_in    (tx_pop),
    .rd_addr_in  (tx_rptr_reg),
    .rd_data_out (tx_data_out)
  );

  // cycles since the last strobe release, for the hold checks
  logic [PBF_HOLD_W-1:0] rx_since_reg;
  logic [PBF_HOLD_W-1:0] tx_since_reg;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rx_since_reg <= HOLD_SAT;
      tx_since_reg <= HOLD_SAT;
    end else begin
      rx_since_reg <= async_rd_rise ? '0 : (rx_since_reg == HOLD_SAT ? HOLD_SAT : rx_since_reg + 1'b1);
      tx_since_reg <= async_wr_rise ? '0 : (tx_since_reg == HOLD_SAT ? HOLD_SAT : tx_since_reg + 1'b1);
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  rx_empty_flag_a: assert property (!rxf_n_out && rx_st_reg != PBF_FL_STROBE |-> rx_count_reg != '0)
    else $error("receive flag low with empty buffer");
  tx_full_flag_a: assert property (tx_count_reg == FULL_CNT |-> txe_n_out)
    else $error("transmit flag low with full buffer");
  rd_bus_drive_a: assert property (!sync_reg && !$past(sync_reg) && !host_data_oe_n_out |-> !$past(host_in.rd_n))
    else $error("bus driven without read strobe");
  rd_advance_a: assert property (async_rd_fall && rx_count_reg != '0 |=> rx_rptr_reg == AW'($past(rx_rptr_reg) + 1'b1))
    else $error("read strobe did not advance buffer");
  wr_capture_a: assert property (async_wr_fall && tx_count_reg != FULL_CNT |=> tx_wptr_reg == AW'($past(tx_wptr_reg) + 1'b1))
    else $error("write strobe did not capture byte");
  rxf_on_rise_a: assert property (async_rd_rise && rx_st_reg == PBF_FL_STROBE |=> rxf_n_out [*2])
    else $error("receive flag not raised after read");
  txe_on_fall_a: assert property (async_wr_fall |=> txe_n_out)
    else $error("transmit flag not raised by write");
  rx_hold_time_a: assert property ($fell(rxf_n_out) && !$past(sync_reg) |-> $past(rx_since_reg) >= PBF_HOLD_W'(PBF_FLAG_HOLD_CYC))
    else $error("receive flag hold too short");
  tx_hold_time_a: assert property ($fell(txe_n_out) && !$past(sync_reg) |-> $past(tx_since_reg) >= PBF_HOLD_W'(PBF_FLAG_HOLD_CYC))
    else $error("transmit flag hold too short");
  small_pkg_a: assert property (pkg32_in |=> !sync_reg ##1 !clkout_out)
    else $error("synchronous mode on small package");
  sync_burst_a: assert property (sync_reg && $past(sync_reg) && rx_count_reg != '0 |-> !rxf_n_out)
    else $error("receive flag high during burst");
  ignore_empty_a: assert property (rd_req && rx_count_reg == '0 |=> $stable(rx_rptr_reg))
    else $error("empty read moved pointer");

  async_read_c: cover property (async_rd_fall && rx_count_reg != '0 ##[1:20] async_rd_rise);
  async_write_c: cover property (async_wr_fall && tx_count_reg != FULL_CNT ##[1:20] async_wr_rise);
  sync_burst_c: cover property (sync_reg && rx_pop ##2 rx_pop ##2 rx_pop);
  tx_fills_c: cover property (tx_count_reg == FULL_CNT);
endmodule

// [pbf_pkg.sv]
// constants and types shared by the parallel byte fifo port
// Notes on behaviour
// - receive flag high means nothing to read
// - receive flag low means a byte waits
// - transmit flag high means buffer cannot accept
// - drive data bus only while read low
// - read falling edge advances receive buffer
// - write falling edge captures bus byte
// - asynchronous bus enable follows read strobe
// - read rising raises receive flag
// - write falling raises transmit flag in asynchronous mode
// - receive flag high 100 ns after read
// - transmit flag high 100 ns after write
// - synchronous mode adds enable input, clock output
// - no synchronous mode on small package
// - synchronous bursts keep flags low while possible
package pbf_pkg;
  localparam int unsigned PBF_DATA_W        = 8;
  localparam int unsigned PBF_DEPTH         = 16;
  localparam int unsigned PBF_CLK_PERIOD_NS = 5;
  localparam int unsigned PBF_FLAG_HOLD_NS  = 100;
  localparam int unsigned PBF_FLAG_HOLD_CYC = (PBF_FLAG_HOLD_NS + PBF_CLK_PERIOD_NS - 1) / PBF_CLK_PERIOD_NS;
  localparam int unsigned PBF_HOLD_W        = 8;
  localparam logic        PBF_FLAG_RST      = 1'b1;
  localparam logic        PBF_OE_N_RST      = 1'b1;

  typedef enum logic [1:0] {
    PBF_FL_READY,
    PBF_FL_STROBE,
    PBF_FL_HOLD
  } pbf_flag_state_t;

  typedef struct packed {
    logic                  rd_n;
    logic                  wr_n;
    logic                  oe_n;
    logic [PBF_DATA_W-1:0] data;
  } pbf_host_in_t;
endpackage

// [pbf_mem.sv]
// small buffer memory with registered read data
`timescale 1ns/100ps
module pbf_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  input  wire logic             wr_en_in,
  input  wire logic [AW-1:0]    wr_addr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             rd_en_in,
  input  wire logic [AW-1:0]    rd_addr_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rd_data_out <= '0;
    end else if (rd_en_in) begin
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end
endmodule

// [pbf_host_model.sv]
// host model driving the parallel byte fifo port
`timescale 1ns/100ps
module pbf_host_model
  import pbf_pkg::*;
(
  input  wire logic                  clk_sys_in,
  input  wire logic [PBF_DATA_W-1:0] dev_data_in,
  input  wire logic                  dev_oe_n_in,
  input  wire logic                  rxf_n_in,
  input  wire logic                  txe_n_in,
  input  wire logic                  clkout_in,
  output pbf_pkg::pbf_host_in_t      host_out
);
  logic                  rd_n      = 1'b1;
  logic                  wr_n      = 1'b1;
  logic                  oe_n      = 1'b1;
  logic                  drv_en    = 1'b0;
  logic [PBF_DATA_W-1:0] drv_data  = 8'h00;
  logic [PBF_DATA_W-1:0] last_wire = 8'h00;
  logic [PBF_DATA_W-1:0] wire_val;

  // released bus flips every cycle so a stale byte never passes
  assign wire_val = !dev_oe_n_in ? dev_data_in : (drv_en ? drv_data : ~last_wire);
  assign host_out = {rd_n, wr_n, oe_n, wire_val};

  always @(posedge clk_sys_in) begin
    last_wire <= wire_val;
  end

  task automatic step();
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic wait_low(input logic rx, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      if ((rx ? rxf_n_in : txe_n_in) === 1'b0) ok = 1'b1;
      else step();
    end
  endtask

  task automatic read_byte(input logic wait_flag, output logic ok, output logic [7:0] d, output logic oe_seen);
    ok = 1'b1;
    if (wait_flag) wait_low(1'b1, ok);
    rd_n = 1'b0;
    step();
    step();
    d = wire_val;
    oe_seen = dev_oe_n_in;
    rd_n = 1'b1;
  endtask

  task automatic write_byte(input logic wait_flag, input logic [7:0] d, output logic ok, output logic txe_seen);
    ok = 1'b1;
    if (wait_flag) wait_low(1'b0, ok);
    drv_data = d;
    drv_en = 1'b1;
    wr_n = 1'b0;
    step();
    step();
    txe_seen = txe_n_in;
    wr_n = 1'b1;
    step();
    drv_en = 1'b0;
  endtask

  // synchronous burst of two reads, strobe set just after clkout falls
  task automatic sync_read2(output logic ok, output logic [7:0] d0, output logic [7:0] d1);
    ok = 1'b0;
    oe_n = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      step();
      ok = (clkout_in === 1'b0) && (rxf_n_in === 1'b0);
    end
    rd_n = 1'b0;
    step();
    step();
    d0 = wire_val;
    step();
    step();
    d1 = wire_val;
    rd_n = 1'b1;
    oe_n = 1'b1;
  endtask

  // synchronous burst of two writes, one byte per rising clkout
  task automatic sync_write2(input logic [7:0] d0, input logic [7:0] d1, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      step();
      ok = (clkout_in === 1'b0) && (txe_n_in === 1'b0);
    end
    drv_data = d0;
    drv_en = 1'b1;
    wr_n = 1'b0;
    step();
    step();
    drv_data = d1;
    step();
    step();
    wr_n = 1'b1;
    drv_en = 1'b0;
  endtask
endmodule

// [pbf_port_test.sv]
// testbench for the parallel byte fifo port
`timescale 1ns/100ps
module pbf_port_test;
  import pbf_pkg::*;
  logic         clk_sys_in      = 1'b0;
  logic         reset_in        = 1'b1;
  logic         sync_req_in     = 1'b0;
  logic         pkg32_in        = 1'b0;
  logic         rx_push_in      = 1'b0;
  logic [7:0]   rx_push_data_in = 8'h00;
  logic         tx_pop_in       = 1'b0;
  pbf_host_in_t host_in;
  logic [7:0]   host_data_out;
  logic [7:0]   tx_data_out;
  logic         host_data_oe_n_out;
  logic         rxf_n_out;
  logic         txe_n_out;
  logic         clkout_out;
  logic         rx_space_out;
  logic         tx_valid_out;
  logic         tx_avail_out;
  int           miscompares     = 0;
  int           checks          = 0;

  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  pbf_port #(.DATA_W(PBF_DATA_W), .DEPTH(PBF_DEPTH)) dut_u (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .sync_req_in(sync_req_in), .pkg32_in(pkg32_in),
    .host_in(host_in), .host_data_out(host_data_out), .host_data_oe_n_out(host_data_oe_n_out),
    .rxf_n_out(rxf_n_out), .txe_n_out(txe_n_out), .clkout_out(clkout_out), .rx_push_in(rx_push_in),
    .rx_push_data_in(rx_push_data_in), .rx_space_out(rx_space_out), .tx_pop_in(tx_pop_in),
    .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out), .tx_avail_out(tx_avail_out)
  );

  pbf_host_model host_u (
    .clk_sys_in(clk_sys_in), .dev_data_in(host_data_out), .dev_oe_n_in(host_data_oe_n_out),
    .rxf_n_in(rxf_n_out), .txe_n_in(txe_n_out), .clkout_in(clkout_out), .host_out(host_in)
  );

  task automatic step();
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hold_chk(input logic rx, input string what);
    int n;
    step();
    chk(what, 8'h1, {7'h0, (rx ? rxf_n_out : txe_n_out)});
    n = 0;
    while ((rx ? rxf_n_out : txe_n_out) === 1'b1 && n < 200) begin
      step();
      n++;
    end
    chk(what, 8'h1, {7'h0, (n >= PBF_FLAG_HOLD_CYC) && (n < 200)});
  endtask

  task automatic pop_chk(input logic [7:0] exp);
    tx_pop_in = 1'b1;
    step();
    tx_pop_in = 1'b0;
    for (int i = 0; i < 3 && tx_valid_out !== 1'b1; i++) step();
    chk("tx_data", exp, (tx_valid_out === 1'b1) ? tx_data_out : 8'hxx);
    step();
  endtask

  task automatic t_reset();
    chk("rxf_n", 8'h1, {7'h0, rxf_n_out});
    chk("txe_n", 8'h0, {7'h0, txe_n_out});
    chk("oe_n", 8'h1, {7'h0, host_data_oe_n_out});
    chk("clkout", 8'h0, {7'h0, clkout_out});
    chk("rx_space", 8'h1, {7'h0, rx_space_out});
  endtask

  task automatic t_read();
    logic       ok;
    logic       oe;
    logic [7:0] d;
    rx_push_in = 1'b1;
    rx_push_data_in = 8'h5a;
    step();
    rx_push_data_in = 8'ha5;
    step();
    rx_push_in = 1'b0;
    host_u.read_byte(1'b1, ok, d, oe);
    chk("rd_wait", 8'h1, {7'h0, ok});
    chk("rd_data", 8'h5a, d);
    chk("rd_oe_n", 8'h0, {7'h0, oe});
    hold_chk(1'b1, "rxf_hold");
    host_u.read_byte(1'b1, ok, d, oe);
    chk("rd_next", 8'ha5, d);
    step();
    step();
    chk("oe_n_idle", 8'h1, {7'h0, host_data_oe_n_out});
    repeat (40) step();
    chk("rxf_empty", 8'h1, {7'h0, rxf_n_out});
    host_u.read_byte(1'b0, ok, d, oe);
    chk("rd_empty", 8'ha5, d);
    step();
  endtask

  task automatic t_write();
    logic ok;
    logic te;
    host_u.write_byte(1'b1, 8'h3c, ok, te);
    chk("txe_strobe", 8'h1, {7'h0, te});
    hold_chk(1'b0, "txe_hold");
    pop_chk(8'h3c);
  endtask

  task automatic t_full();
    logic ok;
    logic te;
    rx_push_in = 1'b1;
    for (int i = 0; i <= PBF_DEPTH; i++) begin
      rx_push_data_in = 8'(i * 17);
      step();
    end
    rx_push_in = 1'b0;
    chk("rx_space", 8'h0, {7'h0, rx_space_out});
    for (int i = 0; i < PBF_DEPTH; i++) begin
      host_u.write_byte(1'b1, 8'(i * 17), ok, te);
      chk("wr_wait", 8'h1, {7'h0, ok});
    end
    repeat (40) step();
    chk("txe_full", 8'h1, {7'h0, txe_n_out});
    host_u.write_byte(1'b0, 8'hee, ok, te);
    chk("txe_full_wr", 8'h1, {7'h0, te});
    for (int i = 0; i < PBF_DEPTH; i++) pop_chk(8'(i * 17));
    chk("tx_avail", 8'h0, {7'h0, tx_avail_out});
  endtask

  task automatic t_sync();
    logic       c0;
    logic       ok;
    logic [7:0] d0;
    logic [7:0] d1;
    pkg32_in = 1'b1;
    sync_req_in = 1'b1;
    repeat (4) step();
    chk("clk_pkg32", 8'h0, {7'h0, clkout_out});
    step();
    chk("clk_pkg32", 8'h0, {7'h0, clkout_out});
    pkg32_in = 1'b0;
    repeat (3) step();
    c0 = clkout_out;
    step();
    chk("clk_sync", 8'h1, {7'h0, c0 ^ clkout_out});
    host_u.sync_read2(ok, d0, d1);
    chk("sync_rd_wait", 8'h1, {7'h0, ok});
    chk("sync_rd0", 8'h00, d0);
    chk("sync_rd1", 8'h11, d1);
    chk("sync_rxf_n", 8'h0, {7'h0, rxf_n_out});
    host_u.sync_write2(8'h71, 8'h72, ok);
    chk("sync_wr_wait", 8'h1, {7'h0, ok});
    chk("sync_txe_n", 8'h0, {7'h0, txe_n_out});
    pop_chk(8'h71);
    pop_chk(8'h72);
    sync_req_in = 1'b0;
    repeat (3) step();
  endtask

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_in);
    #1;
    reset_in = 1'b0;
    step();
    step();
    t_reset();
    t_read();
    t_write();
    t_full();
    t_sync();
    tally_and_finish();
  end
endmodule
